// [rtl/pack_monitor_params.svh]
/*
 * Offsets, field positions, reset values and timing counts of the pack
 * monitor control register set.
 * Assumes a 100 MHz clock; included by bare name where needed.
 */
`ifndef PACK_MONITOR_PARAMS_SVH
`define PACK_MONITOR_PARAMS_SVH

// Register offsets
`define OFS_BLEED_MID 8'h02
`define OFS_BLEED_TOP 8'h03
`define OFS_SYSTEM_CONTROL_FIRST 8'h04
`define OFS_SYSTEM_CONTROL_SECOND 8'h05
`define OFS_SHORT_CFG 8'h06
`define OFS_EXCESS_CFG 8'h07
`define OFS_CELL_DLY_CFG 8'h08
`define OFS_STATUS 8'h00

// Writable masks (reserved read-only bits excluded)
`define MASK_BLEED 8'h1F
`define MASK_SYSTEM_CONTROL_FIRST 8'h1F
`define MASK_SYSTEM_CONTROL_SECOND 8'hFF
`define MASK_SHORT_CFG 8'hBF
`define MASK_EXCESS_CFG 8'h7F
`define MASK_CELL_DLY_CFG 8'hFF
`define RESET_VALUE 8'h00

// Field positions
`define BIT_LOAD_SENSE 7
`define BIT_CONV_EN 4
`define BIT_THERM_SEL 3
`define BIT_KEY_A 1
`define BIT_KEY_B 0
`define BIT_TIMER_BYPASS 7
`define BIT_CC_CONT 6
`define BIT_CC_SINGLE 5
`define BIT_DRAIN_DRIVE 1
`define BIT_FILL_DRIVE 0
`define BIT_RANGE_DBL 7
`define BIT_CC_FRESH 7
`define BIT_STAT_LOW 3
`define BIT_STAT_HIGH 2
`define BIT_STAT_SHORT 1
`define BIT_STAT_EXCESS 0

// Timing: clock rate and delays in their own units
`define CLK_HZ 100000000
`define US_CYCLES(t) ((t) * (`CLK_HZ / 1000000))
`define MS_CYCLES(t) ((t) * (`CLK_HZ / 1000))
`define CONV_MS 250
`define CONV_CYCLES `MS_CYCLES(`CONV_MS)
`define BYPASS_MS 250
`define BYPASS_CYCLES `MS_CYCLES(`BYPASS_MS)

`endif

// [rtl/pack_monitor_pkg.sv]
/*
 * Types shared by the pack monitor control register set.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pack_monitor_pkg;

    // Host register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Shutdown key sequence
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_FAIL
    } key_state_t;

    // Single-shot coulomb counter
    typedef enum logic [0:0] {
        CC_OFF,
        CC_RUN
    } cc_state_t;

    // Fault detector state
    typedef struct packed {
        logic [31:0] count;
        logic fault;
    } fault_timer_t;

endpackage : pack_monitor_pkg

// [rtl/fault_timer.sv]
/*
 * Persistence timer: latches a fault once its condition holds for a
 * delay in cycles. Assumes the delay is stable or changes rarely.
 */
`timescale 1ns/10ps
`default_nettype none
module fault_timer
    import pack_monitor_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Condition and delay
    input wire logic i_cond,
    input wire logic [31:0] i_delay,
    input wire logic i_clear,
    // Latched fault
    output logic o_fault
);
    fault_timer_t st_r;
    fault_timer_t st_nxt;

    // Count while the condition holds, restart when it drops
    always_comb begin
        st_nxt = st_r;
        if (!i_cond) begin
            st_nxt.count = 32'h0;
        end else if (st_r.count + 32'h1 >= i_delay) begin
            st_nxt.fault = 1'b1;
        end else begin
            st_nxt.count = st_r.count + 32'h1;
        end
        if (i_clear && !(i_cond && st_r.count + 32'h1 >= i_delay)) begin
            st_nxt.fault = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_fault = st_r.fault;

    chk_fault_needs_cond : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $rose(st_r.fault) |-> $past(i_cond))
        else $error("fault latched without its condition");

endmodule : fault_timer
`default_nettype wire

// [rtl/shutdown_key.sv]
/*
 * Shutdown key checker: watches host writes to the key bits and
 * raises a request only after the required two-write order.
 * Assumes i_wr pulses one cycle per host write of the register.
 */
`timescale 1ns/10ps
`default_nettype none
module shutdown_key
    import pack_monitor_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Key write
    input wire logic i_wr,
    input wire logic i_key_a,
    input wire logic i_key_b,
    // Result
    output logic o_shutdown
);
    typedef struct packed {
        key_state_t state;
        logic shut;
    } key_regs_t;

    key_regs_t st_r;
    key_regs_t st_nxt;

    // Zero-zero returns to idle, 0/1 arms, then 1/0 shuts; other writes fail until zero-zero
    always_comb begin
        st_nxt = st_r;
        st_nxt.shut = 1'b0;
        if (i_wr) begin
            case (st_r.state)
                KEY_IDLE: begin
                    if (!i_key_a && i_key_b) begin
                        st_nxt.state = KEY_ARMED;
                    end else if (i_key_a || i_key_b) begin
                        st_nxt.state = KEY_FAIL;
                    end
                end
                KEY_ARMED: begin
                    if (i_key_a && !i_key_b) begin
                        st_nxt.shut = 1'b1;
                    end
                    st_nxt.state = (!i_key_a && !i_key_b) ?
                        KEY_IDLE : KEY_FAIL;
                end
                default: begin
                    if (!i_key_a && !i_key_b) begin
                        st_nxt.state = KEY_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_shutdown = st_r.shut;

    chk_shut_order : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        st_r.shut |-> $past(st_r.state) == KEY_ARMED)
        else $error("shutdown without armed key");

endmodule : shutdown_key
`default_nettype wire

// [rtl/pack_monitor_control_regs.sv]
/*
 * Control and protection register set of a multi-cell pack monitor.
 * Assumes a serial register port that delivers one-cycle read and
 * write strobes with address and data, and analog comparators that
 * present fault conditions as synchronous levels.
 */
// How it works
// - Bleed bits enable balancing; bits 7:5 zero
// - Load flag read-only, follows pin while fill off
// - Convert enable zero stops conversions, high-cell protection
// - Thermal select picks die or thermistor results
// - Shutdown only on correct ordered key writes
// - Timer bypass forces quarter-second fault delays
// - Continuous counting ignores single-shot trigger
// - Single shot runs one conversion, self-clears
// - Trigger only when continuous off and fresh clear
// - Drain and fill bits drive gate drivers
// - Range doubler selects upper current thresholds
// - Short delay code gives 70-400 us
// - Short level code selects threshold 22-200 mV
// - Excess delay code gives 8-1280 ms
// - Excess level code selects threshold 8-100 mV
// - Low cell delay code gives 1-16 s
// - High cell delay code gives 1-8 s
// - Fresh flag set by hardware, cleared by writing one
`timescale 1ns/10ps
`default_nettype none
`include "pack_monitor_params.svh"
module pack_monitor_control_regs
    import pack_monitor_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = 100000000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Register port
    input wire reg_req_t i_req,
    output logic [7:0] o_rdata,
    // Analog side
    input wire logic i_fill_pin_loaded,
    input wire logic i_high_cell_cond,
    input wire logic i_low_cell_cond,
    input wire logic i_excess_cond,
    input wire logic i_short_cond,
    // Controls to the analog side
    output logic [9:0] o_cell_bleed_enable,
    output logic o_conv_enable,
    output logic o_high_cell_prot_en,
    output logic o_thermal_ext_sel,
    output logic o_cc_active,
    output logic o_drain_switch_drive,
    output logic o_fill_switch_drive,
    output logic o_sense_range_doubler,
    output logic [2:0] o_short_trip_level,
    output logic [3:0] o_excess_current_level,
    output logic o_shutdown_req,
    // Latched faults
    output logic o_high_cell_fault,
    output logic o_low_cell_fault,
    output logic o_excess_current_fault,
    output logic o_short_circuit_fault
);
    typedef struct packed {
        logic [4:0] bleed_mid;
        logic [4:0] bleed_top;
        logic [4:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] short_cfg;
        logic [6:0] excess_cfg;
        logic [7:0] dly_cfg;
        logic load_sense;
        logic fresh;
        cc_state_t cc_state;
        logic [31:0] cc_count;
        logic [7:0] rdata;
        logic shut;
    } regs_t;

    regs_t st_r;
    regs_t st_nxt;
    logic key_pulse;
    logic [3:0] faults;
    logic [31:0] dly [4];
    logic wr_stat;
    logic cc_done;

    // Delay in cycles for each fault detector
    // A code rewritten mid-count applies at once to the running timer
    always_comb begin
        case (st_r.short_cfg[4:3])
            2'h0: dly[0] = `US_CYCLES(70);
            2'h1: dly[0] = `US_CYCLES(100);
            2'h2: dly[0] = `US_CYCLES(200);
            default: dly[0] = `US_CYCLES(400);
        endcase
        dly[1] = 32'(`MS_CYCLES(8)) << st_r.excess_cfg[6:4];
        if (st_r.excess_cfg[6:4] != 3'h0) begin
            dly[1] = 32'(`MS_CYCLES(10)) << st_r.excess_cfg[6:4];
        end
        case (st_r.dly_cfg[7:6])
            2'h0: dly[2] = SEC_CYCLES;
            2'h1: dly[2] = SEC_CYCLES * 4;
            2'h2: dly[2] = SEC_CYCLES * 8;
            default: dly[2] = SEC_CYCLES * 16;
        endcase
        dly[3] = SEC_CYCLES << st_r.dly_cfg[5:4];
        if (st_r.ctrl2[`BIT_TIMER_BYPASS]) begin
            for (int i = 0; i < 4; i++) begin
                dly[i] = `BYPASS_CYCLES;
            end
        end
    end

    // Persistence timers: short, excess, low cell, high cell
    // Faults stay latched until reset; no host clear is wired
    fault_timer u_short (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_cond(i_short_cond),
        .i_delay(dly[0]), .i_clear(1'b0), .o_fault(faults[0]));
    fault_timer u_excess (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_cond(i_excess_cond),
        .i_delay(dly[1]), .i_clear(1'b0), .o_fault(faults[1]));
    fault_timer u_low (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_cond(i_low_cell_cond),
        .i_delay(dly[2]), .i_clear(1'b0), .o_fault(faults[2]));
    fault_timer u_high (
        .i_clk(i_clk), .i_resetn(i_resetn),
        .i_cond(i_high_cell_cond && st_r.ctrl1[`BIT_CONV_EN]),
        .i_delay(dly[3]), .i_clear(1'b0), .o_fault(faults[3]));

    // Shutdown key sequence checker
    shutdown_key u_key (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_wr(i_req.wr && i_req.addr == `OFS_SYSTEM_CONTROL_FIRST),
        .i_key_a(i_req.wdata[`BIT_KEY_A]),
        .i_key_b(i_req.wdata[`BIT_KEY_B]),
        .o_shutdown(key_pulse)
    );

    assign wr_stat = i_req.wr && i_req.addr == `OFS_STATUS;
    assign cc_done = st_r.cc_state == CC_RUN &&
        st_r.cc_count + 32'h1 >= `CONV_CYCLES;

    // Register writes, status flags and single-shot counter
    always_comb begin
        st_nxt = st_r;
        st_nxt.shut = st_r.shut | key_pulse;
        // Load sense tracks pin only while fill drive is off
        st_nxt.load_sense = i_fill_pin_loaded &&
            !st_r.ctrl2[`BIT_FILL_DRIVE];
        if (i_req.wr) begin
            if (i_req.addr == `OFS_BLEED_MID) begin
                st_nxt.bleed_mid = i_req.wdata[4:0];
            end else if (i_req.addr == `OFS_BLEED_TOP) begin
                st_nxt.bleed_top = i_req.wdata[4:0];
            end else if (i_req.addr == `OFS_SYSTEM_CONTROL_FIRST) begin
                st_nxt.ctrl1 = i_req.wdata[4:0];
            end else if (i_req.addr == `OFS_SYSTEM_CONTROL_SECOND) begin
                st_nxt.ctrl2 = i_req.wdata;
                // Trigger accepted only from an idle, clear state
                if (i_req.wdata[`BIT_CC_CONT] || st_r.fresh ||
                    st_r.cc_state == CC_RUN) begin
                    st_nxt.ctrl2[`BIT_CC_SINGLE] =
                        st_r.ctrl2[`BIT_CC_SINGLE];
                end
            end else if (i_req.addr == `OFS_SHORT_CFG) begin
                st_nxt.short_cfg = i_req.wdata & `MASK_SHORT_CFG;
            end else if (i_req.addr == `OFS_EXCESS_CFG) begin
                st_nxt.excess_cfg = i_req.wdata[6:0];
            end else if (i_req.addr == `OFS_CELL_DLY_CFG) begin
                st_nxt.dly_cfg = i_req.wdata;
            end
        end
        // Write-one-to-clear of the fresh flag
        if (wr_stat && i_req.wdata[`BIT_CC_FRESH]) begin
            st_nxt.fresh = 1'b0;
        end
        // Single-shot conversion sequencer
        case (st_r.cc_state)
            CC_OFF: begin
                st_nxt.cc_count = 32'h0;
                if (st_nxt.ctrl2[`BIT_CC_SINGLE] &&
                    !st_nxt.ctrl2[`BIT_CC_CONT]) begin
                    st_nxt.cc_state = CC_RUN;
                end
            end
            default: begin
                st_nxt.cc_count = st_r.cc_count + 32'h1;
                if (cc_done) begin
                    st_nxt.cc_state = CC_OFF;
                    st_nxt.ctrl2[`BIT_CC_SINGLE] = 1'b0;
                end
            end
        endcase
        // Continuous mode produces a result every conversion period
        if (st_r.ctrl2[`BIT_CC_CONT] && st_r.cc_state == CC_OFF) begin
            st_nxt.cc_count = st_r.cc_count + 32'h1;
            if (st_r.cc_count + 32'h1 >= `CONV_CYCLES) begin
                st_nxt.cc_count = 32'h0;
                st_nxt.fresh = 1'b1;
            end
        end
        if (cc_done) begin
            st_nxt.fresh = 1'b1;
        end
        // Read data, registered
        st_nxt.rdata = 8'h00;
        if (i_req.rd) begin
            if (i_req.addr == `OFS_BLEED_MID) begin
                st_nxt.rdata = {3'h0, st_r.bleed_mid};
            end else if (i_req.addr == `OFS_BLEED_TOP) begin
                st_nxt.rdata = {3'h0, st_r.bleed_top};
            end else if (i_req.addr == `OFS_SYSTEM_CONTROL_FIRST) begin
                st_nxt.rdata = {st_r.load_sense, 2'h0, st_r.ctrl1};
            end else if (i_req.addr == `OFS_SYSTEM_CONTROL_SECOND) begin
                st_nxt.rdata = st_r.ctrl2;
            end else if (i_req.addr == `OFS_SHORT_CFG) begin
                st_nxt.rdata = st_r.short_cfg;
            end else if (i_req.addr == `OFS_EXCESS_CFG) begin
                st_nxt.rdata = {1'b0, st_r.excess_cfg};
            end else if (i_req.addr == `OFS_CELL_DLY_CFG) begin
                st_nxt.rdata = st_r.dly_cfg;
            end else if (i_req.addr == `OFS_STATUS) begin
                st_nxt.rdata = {st_r.fresh, 3'h0, faults[2], faults[3],
                    faults[0], faults[1]};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from registers
    assign o_rdata = st_r.rdata;
    assign o_cell_bleed_enable = {st_r.bleed_top, st_r.bleed_mid};
    assign o_conv_enable = st_r.ctrl1[`BIT_CONV_EN];
    assign o_high_cell_prot_en = st_r.ctrl1[`BIT_CONV_EN];
    assign o_thermal_ext_sel = st_r.ctrl1[`BIT_THERM_SEL];
    assign o_cc_active = st_r.cc_state == CC_RUN ||
        st_r.ctrl2[`BIT_CC_CONT];
    assign o_drain_switch_drive = st_r.ctrl2[`BIT_DRAIN_DRIVE];
    assign o_fill_switch_drive = st_r.ctrl2[`BIT_FILL_DRIVE];
    assign o_sense_range_doubler = st_r.short_cfg[`BIT_RANGE_DBL];
    assign o_short_trip_level = st_r.short_cfg[2:0];
    assign o_excess_current_level = st_r.excess_cfg[3:0];
    assign o_shutdown_req = st_r.shut;
    assign o_short_circuit_fault = faults[0];
    assign o_excess_current_fault = faults[1];
    assign o_low_cell_fault = faults[2];
    assign o_high_cell_fault = faults[3];

    // Named steps of the single-shot sequence
    sequence trigger_taken;
        st_r.cc_state == CC_OFF && st_nxt.cc_state == CC_RUN;
    endsequence

    // Host write asking for continuous counting, no shot ending
    sequence cont_write;
        i_req.wr && i_req.addr == `OFS_SYSTEM_CONTROL_SECOND &&
            i_req.wdata[`BIT_CC_CONT] && !cc_done;
    endsequence

    // Host write of the second control register while an old result is unread
    sequence shot_refused;
        i_req.wr && i_req.addr == `OFS_SYSTEM_CONTROL_SECOND && st_r.fresh &&
            st_r.cc_state == CC_OFF;
    endsequence

    chk_trigger_gate : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        trigger_taken |-> !st_nxt.ctrl2[`BIT_CC_CONT])
        else $error("single shot started in continuous mode");

    chk_shot_selfclear : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        cc_done |=> !st_r.ctrl2[`BIT_CC_SINGLE] && st_r.fresh)
        else $error("single shot did not clear or set fresh");

    chk_load_sense : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        st_r.load_sense |-> $past(!st_r.ctrl2[`BIT_FILL_DRIVE]))
        else $error("load flag set with fill drive on");

    chk_fresh_hold : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $fell(st_r.fresh) |-> $past(wr_stat))
        else $error("fresh flag dropped without host clear");

    chk_bleed_pad : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $past(i_req.rd) && $past(i_req.addr) == `OFS_BLEED_MID
        |-> o_rdata[7:5] == 3'h0)
        else $error("bleed reserved bits not zero");

    chk_drive_follow : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $past(i_req.wr) && $past(i_req.addr) == `OFS_SYSTEM_CONTROL_SECOND
        |-> o_fill_switch_drive == $past(i_req.wdata[0]))
        else $error("fill drive did not follow write");

    chk_excess_pad : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $past(i_req.rd) && $past(i_req.addr) == `OFS_EXCESS_CFG
        |-> !o_rdata[7])
        else $error("excess config bit 7 not zero");

    chk_bleed_top_pad : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $past(i_req.rd) && $past(i_req.addr) == `OFS_BLEED_TOP
        |-> o_rdata[7:5] == 3'h0)
        else $error("upper bleed reserved bits not zero");

    chk_unmapped_zero : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $past(i_req.rd) && ($past(i_req.addr) == 8'h01 ||
            $past(i_req.addr) > `OFS_CELL_DLY_CFG) |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");

    chk_high_gate : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $rose(faults[3]) |-> $past(st_r.ctrl1[`BIT_CONV_EN]))
        else $error("high cell fault while conversions off");

    chk_shut_sticky : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        st_r.shut |=> st_r.shut)
        else $error("shutdown request dropped before reset");

    chk_cont_ignores : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        cont_write
        |=> st_r.ctrl2[`BIT_CC_SINGLE] == $past(st_r.ctrl2[`BIT_CC_SINGLE]))
        else $error("trigger changed by a continuous-mode write");

    chk_shot_refused : assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        shot_refused |=> st_r.cc_state == CC_OFF)
        else $error("single shot started with fresh flag set");

endmodule : pack_monitor_control_regs
`default_nettype wire

// [verification/host_port_model.sv]
/*
 * Host side of the register port: one-cycle read and write strobes.
 * Assumes requests are taken at the rising edge of i_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pack_monitor_params.svh"
module host_port_model
    import pack_monitor_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Register port
    output var reg_req_t o_req,
    input wire logic [7:0] i_rdata
);
    // Idle port until the first call
    initial o_req = '0;

    // Write held across one rising edge, released after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '0;
    endtask : wr

    // Read data is sampled in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_clk);
        d = i_rdata;
        o_req = '0;
    endtask : rd

    // All-zero write, then the two ordered key writes
    task automatic shut_seq();
        wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h00);
        wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h01);
        wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h02);
    endtask : shut_seq
endmodule : host_port_model
`default_nettype wire

// [verification/tb.sv]
/*
 * Self-checking bench of the pack monitor control registers.
 * Assumes a 100 MHz clock and a shortened one-second count.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pack_monitor_params.svh"
module tb;
    import pack_monitor_pkg::*;
    localparam int unsigned SEC = 1000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t req;
    logic [7:0] rdata, d;
    logic loaded = 1'b0, hi_c = 1'b0, lo_c = 1'b0, ex_c = 1'b0;
    logic sh_c = 1'b0;
    logic [9:0] bleed;
    logic conv, hprot, therm, cc, drain, fill, dbl, shut;
    logic [2:0] s_lvl;
    logic [3:0] e_lvl;
    logic f_hi, f_lo, f_ex, f_sh;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] offs [6] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
    logic [7:0] back [6] = '{8'h1F, 8'h1F, 8'h1F, 8'hBF, 8'h7F, 8'hFF};

    // Clock of 10 ns period
    always #5 clk = ~clk;

    host_port_model i_host (.i_clk(clk), .o_req(req), .i_rdata(rdata));

    pack_monitor_control_regs #(.SEC_CYCLES(SEC)) i_dut (
        .i_clk(clk), .i_resetn(resetn), .i_req(req), .o_rdata(rdata),
        .i_fill_pin_loaded(loaded), .i_high_cell_cond(hi_c),
        .i_low_cell_cond(lo_c), .i_excess_cond(ex_c),
        .i_short_cond(sh_c), .o_cell_bleed_enable(bleed),
        .o_conv_enable(conv), .o_high_cell_prot_en(hprot),
        .o_thermal_ext_sel(therm), .o_cc_active(cc),
        .o_drain_switch_drive(drain), .o_fill_switch_drive(fill),
        .o_sense_range_doubler(dbl), .o_short_trip_level(s_lvl),
        .o_excess_current_level(e_lvl), .o_shutdown_req(shut),
        .o_high_cell_fault(f_hi), .o_low_cell_fault(f_lo),
        .o_excess_current_fault(f_ex), .o_short_circuit_fault(f_sh)
    );

    // Compare seen against expected, count both
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    // Read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        check(d, exp);
    endtask : rchk

    // Reset held for five cycles, released off the edge
    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
    endtask : do_reset

    // Wait whole cycles at the falling edge
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // Counts and verdict
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // Cuts a hang short
    initial begin
        #500000;
        error_cnt++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        wrap_up();
    end

    // Main sequence
    initial begin
        do_reset();
        // Reset values, unmapped places read zero
        for (int a = 0; a < 10; a++) begin
            rchk(8'(a), 8'h00);
        end
        // All ones written, reserved read-only bits stay zero
        for (int i = 0; i < 6; i++) begin
            i_host.wr(offs[i], 8'hFF);
            rchk(offs[i], back[i]);
        end
        i_host.wr(`OFS_SYSTEM_CONTROL_SECOND, 8'hDF);
        rchk(`OFS_SYSTEM_CONTROL_SECOND, 8'hDF);
        check(bleed, 10'h3FF);
        check({conv, hprot}, 10'h003);
        check(therm, 10'h001);
        check({drain, fill}, 10'h003);
        check(dbl, 10'h001);
        check(s_lvl, 10'h007);
        check(e_lvl, 10'h00F);
        check(cc, 10'h001);
        // Single shot ignored while continuous counting runs
        i_host.wr(`OFS_SYSTEM_CONTROL_SECOND, 8'hFF);
        rchk(`OFS_SYSTEM_CONTROL_SECOND, 8'hDF);
        // Load flag only while fill drive is off
        loaded = 1'b1;
        rchk(`OFS_SYSTEM_CONTROL_FIRST, 8'h1F);
        i_host.wr(`OFS_SYSTEM_CONTROL_SECOND, 8'h00);
        check(cc, 10'h000);
        rchk(`OFS_SYSTEM_CONTROL_FIRST, 8'h9F);
        i_host.wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h00);
        rchk(`OFS_SYSTEM_CONTROL_FIRST, 8'h80);
        loaded = 1'b0;
        rchk(`OFS_SYSTEM_CONTROL_FIRST, 8'h00);
        // Single shot starts and stands while running
        i_host.wr(`OFS_SYSTEM_CONTROL_SECOND, 8'h20);
        check(cc, 10'h001);
        rchk(`OFS_SYSTEM_CONTROL_SECOND, 8'h20);
        do_reset();
        // Key writes out of order are ignored
        i_host.wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h02);
        i_host.wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h01);
        i_host.wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h03);
        idle(2);
        check(shut, 10'h000);
        i_host.shut_seq();
        idle(2);
        check(shut, 10'h001);
        // Low cell: a break restarts the one-second count
        lo_c = 1'b1;
        idle(SEC - 100);
        lo_c = 1'b0;
        idle(2);
        check(f_lo, 10'h000);
        lo_c = 1'b1;
        idle(SEC - 50);
        check(f_lo, 10'h000);
        idle(100);
        check(f_lo, 10'h001);
        rchk(`OFS_STATUS, 8'h08);
        // High cell protection waits for convert enable
        hi_c = 1'b1;
        idle(SEC + 500);
        check(f_hi, 10'h000);
        i_host.wr(`OFS_SYSTEM_CONTROL_FIRST, 8'h10);
        idle(SEC - 50);
        check(f_hi, 10'h000);
        idle(100);
        check(f_hi, 10'h001);
        // Shortest short-trip delay code suits low input resistance
        sh_c = 1'b1;
        idle(`US_CYCLES(70) - 50);
        check(f_sh, 10'h000);
        idle(100);
        check(f_sh, 10'h001);
        check(f_ex, 10'h000);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
